// ### src/ucsaf_regs.vh
// Constants for the alpha-field text record codec.
// Assumes inclusion by the codec modules only; holds definitions and nothing else.
//
// Notes on behaviour
// - All three 16-bit schemes supported, pair scheme always.
// - One coding per record, never mixed.
// - Default-alphabet-only records encode as plain 7-bit.
// - Scheme 80: byte pairs, first byte high.
// - Scheme 80 encode pads unused bytes with FF.
// - Scheme 81: count byte limits decoded characters.
// - Scheme 81 base: third byte into bits 14..7.
// - Scheme 81: bit 7 selects alphabet or offset.
// - Scheme 82: count, then full 16-bit base.
// - Scheme 82 characters from fifth byte, same split.
// - FF inside count is offset 7F character.
`ifndef UCSAF_REGS_VH
`define UCSAF_REGS_VH
// Lead byte values that select a scheme.
`define UCSAF_LEAD_PAIR 8'h80
`define UCSAF_LEAD_HALF 8'h81
`define UCSAF_LEAD_FULL 8'h82
// Padding byte value.
`define UCSAF_PAD 8'hFF
// Bit that splits a counted-scheme character byte.
`define UCSAF_HIGH_BIT 7
// Shift that places the half-page byte in the base pointer.
`define UCSAF_HALF_SHIFT 7
`endif

// ### src/ucsaf_enc.v
// Encoder for one record: picks plain 7-bit when every character is default alphabet,
// else the pair scheme. Assumes the source gives a whole record length up front.
`timescale 1ns/1ps
`include "ucsaf_regs.vh"
module ucsaf_enc (
  // Clock and reset.
  input wire CLOCK,
  input wire RESET_N,
  // Record start and length in bytes.
  input wire START,
  input wire [7:0] FIELD_LEN,
  input wire ALL_DEFAULT,
  // Character input.
  input wire CHAR_VALID,
  output wire CHAR_READY,
  input wire [15:0] CHAR_CODE,
  input wire CHAR_LAST,
  // Byte output.
  output reg BYTE_VALID,
  output reg [7:0] BYTE_DATA,
  output reg BYTE_LAST
);
  // Encoder states, one-hot.
  localparam [4:0] S_IDLE = 5'h01;
  localparam [4:0] S_LEAD = 5'h02;
  localparam [4:0] S_HI = 5'h04;
  localparam [4:0] S_LO = 5'h08;
  localparam [4:0] S_PAD = 5'h10;
  reg [4:0] state_reg;
  reg [7:0] left_reg; // Bytes still owed to the field.
  reg plain_reg; // Record goes out as plain 7-bit.
  reg [7:0] lo_reg; // Low half waiting behind its high half.
  reg done_reg; // Source sent its last character.
  // A character is taken in plain mode, or as the high half of a pair.
  // A pair needs two free bytes; offering ready with only one left would drop the character.
  assign CHAR_READY = ((state_reg == S_HI && left_reg >= 8'h02) || (state_reg == S_LO && plain_reg && left_reg != 8'h00))
    && !done_reg;
  // Main sequencer; every byte owed to the field is emitted, padding included.
  always @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      state_reg <= S_IDLE;
      left_reg <= 8'h00;
      plain_reg <= 1'b0;
      lo_reg <= 8'h00;
      done_reg <= 1'b0;
      BYTE_VALID <= 1'b0;
      BYTE_DATA <= 8'h00;
      BYTE_LAST <= 1'b0;
    end else begin
      BYTE_VALID <= 1'b0;
      BYTE_LAST <= 1'b0;
      case (state_reg)
        S_IDLE: begin
          if (START && FIELD_LEN != 8'h00) begin
            left_reg <= FIELD_LEN;
            plain_reg <= ALL_DEFAULT;
            done_reg <= 1'b0;
            state_reg <= ALL_DEFAULT ? S_LO : S_LEAD;
          end
        end
        S_LEAD: begin
          BYTE_VALID <= 1'b1;
          BYTE_DATA <= `UCSAF_LEAD_PAIR;
          BYTE_LAST <= (left_reg == 8'h01);
          left_reg <= left_reg - 8'h01;
          state_reg <= (left_reg == 8'h01) ? S_IDLE : S_HI;
        end
        S_HI: begin
          if (left_reg < 8'h02 || done_reg) begin
            state_reg <= S_PAD;
          end else if (CHAR_VALID) begin
            BYTE_VALID <= 1'b1;
            BYTE_DATA <= CHAR_CODE[15:8];
            lo_reg <= CHAR_CODE[7:0];
            done_reg <= CHAR_LAST;
            left_reg <= left_reg - 8'h01;
            state_reg <= S_LO;
          end
        end
        S_LO: begin
          if (plain_reg) begin
            // Plain mode: one byte per character, then padding.
            if (left_reg == 8'h00) begin
              state_reg <= S_IDLE;
            end else if (done_reg) begin
              state_reg <= S_PAD;
            end else if (CHAR_VALID) begin
              BYTE_VALID <= 1'b1;
              BYTE_DATA <= {1'b0, CHAR_CODE[6:0]};
              BYTE_LAST <= (left_reg == 8'h01);
              done_reg <= CHAR_LAST;
              left_reg <= left_reg - 8'h01;
            end
          end else begin
            BYTE_VALID <= 1'b1;
            BYTE_DATA <= lo_reg;
            BYTE_LAST <= (left_reg == 8'h01);
            left_reg <= left_reg - 8'h01;
            state_reg <= (left_reg == 8'h01) ? S_IDLE : S_HI;
          end
        end
        S_PAD: begin
          // Unused and unusable bytes are filled with padding.
          BYTE_VALID <= 1'b1;
          BYTE_DATA <= `UCSAF_PAD;
          BYTE_LAST <= (left_reg == 8'h01);
          left_reg <= left_reg - 8'h01;
          if (left_reg == 8'h01) begin
            state_reg <= S_IDLE;
          end
        end
        default: begin
          state_reg <= S_IDLE;
        end
      endcase
    end
  end
endmodule // ucsaf_enc

// ### src/ucsaf_codec.v
// Alpha-field record codec top: decodes record bytes into flagged characters and
// hosts the record encoder. Assumes a byte source with valid/last and a consumer that
// takes one character each cycle it is offered; inputs are synchronous to CLOCK.
`timescale 1ns/1ps
`include "ucsaf_regs.vh"
module ucsaf_codec (
  // Clock and reset.
  input wire CLOCK,
  input wire RESET_N,
  // Record bytes in for decoding.
  input wire IN_VALID,
  input wire [7:0] IN_BYTE,
  input wire IN_LAST,
  // Decoded characters out.
  output reg OUT_VALID,
  output reg [15:0] OUT_CODE,
  output reg OUT_WIDE,
  output reg OUT_DONE,
  // Encoder side: record setup.
  input wire ENC_START,
  input wire [7:0] ENC_LEN,
  input wire ENC_ALL_DEFAULT,
  // Encoder side: characters in.
  input wire ENC_VALID,
  output wire ENC_READY,
  input wire [15:0] ENC_CODE,
  input wire ENC_LAST,
  // Encoder side: bytes out.
  output wire ENC_BYTE_VALID,
  output wire [7:0] ENC_BYTE,
  output wire ENC_BYTE_LAST
);
  // Decoder states, one-hot.
  localparam [6:0] D_LEAD = 7'h01;
  localparam [6:0] D_PAIR_HI = 7'h02;
  localparam [6:0] D_PAIR_LO = 7'h04;
  localparam [6:0] D_COUNT = 7'h08;
  localparam [6:0] D_BASE_HI = 7'h10;
  localparam [6:0] D_BASE_LO = 7'h20;
  localparam [6:0] D_CHARS = 7'h40;
  // Scheme of the current record, with an extra mode for plain default-alphabet records.
  localparam [1:0] M_PAIR = 2'd0;
  localparam [1:0] M_HALF = 2'd1;
  localparam [1:0] M_FULL = 2'd2;
  localparam [1:0] M_PLAIN = 2'd3;
  reg [6:0] state_reg; // Position within the record.
  reg [1:0] mode_reg; // Scheme fixed by the lead byte for the whole record.
  reg [7:0] count_reg; // Characters still to produce in counted schemes.
  reg [15:0] base_reg; // Base pointer for offsets.
  reg [7:0] hi_reg; // High half of a pair code point.
  reg stop_reg; // Rest of the record is ignored.
  // Splits a counted-scheme byte into alphabet character or offset from the base.
  function [16:0] split_byte;
    input [7:0] b;
    input [15:0] base;
    begin
      if (b[`UCSAF_HIGH_BIT]) begin
        split_byte = {1'b1, base + {9'h000, b[6:0]}};
      end else begin
        split_byte = {1'b0, 9'h000, b[6:0]};
      end
    end
  endfunction
  // ----------------------------------------
  // Record decoder
  // ----------------------------------------
  // Decoder. Bytes after the end of a record's characters are ignored until IN_LAST,
  // which returns the decoder to expect a lead byte. Drops nothing: every accepted
  // byte is handled in its own cycle, so the source never needs to be stalled.
  always @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      state_reg <= D_LEAD;
      mode_reg <= M_PAIR;
      count_reg <= 8'h00;
      base_reg <= 16'h0000;
      hi_reg <= 8'h00;
      stop_reg <= 1'b0;
      OUT_VALID <= 1'b0;
      OUT_CODE <= 16'h0000;
      OUT_WIDE <= 1'b0;
      OUT_DONE <= 1'b0;
    end else begin
      OUT_VALID <= 1'b0;
      OUT_DONE <= 1'b0;
      if (IN_VALID) begin
        if (IN_LAST) begin
          state_reg <= D_LEAD;
          stop_reg <= 1'b0;
          OUT_DONE <= 1'b1;
        end
        case (state_reg)
          D_LEAD: begin
            // The lead byte fixes the scheme for the whole record.
            // A stop left over from the last character of the previous record must not
            // silence this one, so every new record starts with the stop flag clear.
            stop_reg <= 1'b0;
            if (IN_BYTE == `UCSAF_LEAD_PAIR) begin
              mode_reg <= M_PAIR;
              if (!IN_LAST) state_reg <= D_PAIR_HI;
            end else if (IN_BYTE == `UCSAF_LEAD_HALF || IN_BYTE == `UCSAF_LEAD_FULL) begin
              mode_reg <= (IN_BYTE == `UCSAF_LEAD_HALF) ? M_HALF : M_FULL;
              if (!IN_LAST) state_reg <= D_COUNT;
            end else begin
              mode_reg <= M_PLAIN;
              if (IN_BYTE == `UCSAF_PAD) begin
                stop_reg <= 1'b1;
              end else begin
                OUT_VALID <= 1'b1;
                OUT_CODE <= {9'h000, IN_BYTE[6:0]};
                OUT_WIDE <= 1'b0;
              end
              if (!IN_LAST) state_reg <= D_CHARS;
            end
          end
          D_PAIR_HI: begin
            // A pad in the high position ends the useful part of the field.
            if (IN_BYTE == `UCSAF_PAD) begin
              stop_reg <= 1'b1;
            end
            hi_reg <= IN_BYTE;
            if (!IN_LAST) state_reg <= D_PAIR_LO;
          end
          D_PAIR_LO: begin
            if (!stop_reg) begin
              OUT_VALID <= 1'b1;
              OUT_CODE <= {hi_reg, IN_BYTE};
              OUT_WIDE <= 1'b1;
            end
            if (!IN_LAST) state_reg <= D_PAIR_HI;
          end
          D_COUNT: begin
            count_reg <= IN_BYTE;
            stop_reg <= (IN_BYTE == 8'h00);
            if (!IN_LAST) state_reg <= D_BASE_HI;
          end
          D_BASE_HI: begin
            if (mode_reg == M_HALF) begin
              base_reg <= {1'b0, IN_BYTE, 7'h00};
              if (!IN_LAST) state_reg <= D_CHARS;
            end else begin
              base_reg <= {IN_BYTE, 8'h00};
              if (!IN_LAST) state_reg <= D_BASE_LO;
            end
          end
          D_BASE_LO: begin
            base_reg <= {base_reg[15:8], IN_BYTE};
            if (!IN_LAST) state_reg <= D_CHARS;
          end
          D_CHARS: begin
            if (mode_reg == M_PLAIN) begin
              if (IN_BYTE == `UCSAF_PAD) begin
                stop_reg <= 1'b1;
              end else if (!stop_reg) begin
                OUT_VALID <= 1'b1;
                OUT_CODE <= {9'h000, IN_BYTE[6:0]};
                OUT_WIDE <= 1'b0;
              end
            end else if (!stop_reg) begin
              // FF inside the count is a real character, offset 7F.
              OUT_VALID <= 1'b1;
              {OUT_WIDE, OUT_CODE} <= split_byte(IN_BYTE, base_reg);
              count_reg <= count_reg - 8'h01;
              if (count_reg == 8'h01) begin
                stop_reg <= 1'b1;
              end
            end
          end
          default: begin
            state_reg <= D_LEAD;
          end
        endcase
      end
    end
  end
  // ----------------------------------------
  // Record encoder
  // ----------------------------------------
  // Record encoder.
  ucsaf_enc u_enc (
    .CLOCK(CLOCK),
    .RESET_N(RESET_N),
    .START(ENC_START),
    .FIELD_LEN(ENC_LEN),
    .ALL_DEFAULT(ENC_ALL_DEFAULT),
    .CHAR_VALID(ENC_VALID),
    .CHAR_READY(ENC_READY),
    .CHAR_CODE(ENC_CODE),
    .CHAR_LAST(ENC_LAST),
    .BYTE_VALID(ENC_BYTE_VALID),
    .BYTE_DATA(ENC_BYTE),
    .BYTE_LAST(ENC_BYTE_LAST)
  );
endmodule // ucsaf_codec

// ### testbench/ucsaf_codec_checker.sv
// Assertion checker for the alpha-field record codec top.
// Assumes it is bound to ucsaf_codec and sees only its ports.
`timescale 1ns/1ps
module ucsaf_codec_checker (
  // Clock and reset.
  input wire CLOCK,
  input wire RESET_N,
  // Decoder side.
  input wire IN_VALID,
  input wire [7:0] IN_BYTE,
  input wire IN_LAST,
  input wire OUT_VALID,
  input wire [15:0] OUT_CODE,
  input wire OUT_WIDE,
  input wire OUT_DONE,
  // Encoder side.
  input wire ENC_START,
  input wire ENC_ALL_DEFAULT,
  input wire ENC_VALID,
  input wire ENC_READY,
  input wire [15:0] ENC_CODE,
  input wire ENC_BYTE_VALID,
  input wire [7:0] ENC_BYTE,
  input wire ENC_BYTE_LAST
);
  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RESET_N);
  // A pair-scheme record start and its lead byte.
  sequence pair_start;
    ENC_START && !ENC_ALL_DEFAULT;
  endsequence
  sequence lead_out;
    ENC_BYTE_VALID && ENC_BYTE == 8'h80;
  endsequence
  chk_done_after_last: assert property (IN_VALID && IN_LAST |=> OUT_DONE)
    else $error("record end pulse missing");
  chk_done_has_cause: assert property (OUT_DONE |-> $past(IN_VALID && IN_LAST))
    else $error("record end pulse without a last byte");
  chk_char_has_byte: assert property (OUT_VALID |-> $past(IN_VALID))
    else $error("character without an input byte");
  chk_narrow_range: assert property (OUT_VALID && !OUT_WIDE |-> OUT_CODE[15:7] == 9'h000)
    else $error("default-alphabet value wider than seven bits");
  chk_narrow_bits: assert property (OUT_VALID && !OUT_WIDE |-> OUT_CODE[6:0] == $past(IN_BYTE[6:0]))
    else $error("default-alphabet value differs from its byte");
  chk_pair_lead: assert property (pair_start |-> ##[1:3] lead_out)
    else $error("pair record lead byte missing");
  chk_plain_no_lead: assert property (ENC_START && ENC_ALL_DEFAULT |=> (!ENC_BYTE_VALID || !ENC_BYTE[7] || ENC_BYTE == 8'hFF)[*3])
    else $error("scheme byte in a plain record");
  chk_enc_take: assert property (ENC_VALID && ENC_READY |=> ENC_BYTE_VALID
      && (ENC_BYTE == $past(ENC_CODE[15:8]) || ENC_BYTE == {1'b0, $past(ENC_CODE[6:0])}))
    else $error("accepted character gave no matching byte");
  chk_last_is_byte: assert property (ENC_BYTE_LAST |-> ENC_BYTE_VALID)
    else $error("record end flag without a byte");
endmodule // ucsaf_codec_checker
bind ucsaf_codec ucsaf_codec_checker chk (.CLOCK, .RESET_N, .IN_VALID, .IN_BYTE, .IN_LAST, .OUT_VALID,
  .OUT_CODE, .OUT_WIDE, .OUT_DONE, .ENC_START, .ENC_ALL_DEFAULT, .ENC_VALID, .ENC_READY, .ENC_CODE,
  .ENC_BYTE_VALID, .ENC_BYTE, .ENC_BYTE_LAST);

// ### testbench/ucsaf_far.sv
// Partner model: record byte source and character consumer.
// Assumes a free-running clock; bytes change on its falling edge.
`timescale 1ns/1ps
module ucsaf_far (
  // Clock.
  input wire CLOCK,
  // Bytes to the decoder.
  output logic IN_VALID,
  output logic [7:0] IN_BYTE,
  output logic IN_LAST,
  // Characters from the decoder.
  input wire OUT_VALID,
  input wire [15:0] OUT_CODE,
  input wire OUT_WIDE
);
  // Captured characters, wide flag on top.
  logic [16:0] got[$];
  initial begin
    IN_VALID = 1'b0;
    IN_BYTE = 8'h00;
    IN_LAST = 1'b0;
  end
  // The consumer takes each character in the cycle it is offered.
  always @(posedge CLOCK) begin
    if (OUT_VALID === 1'b1) begin
      got.push_back({OUT_WIDE, OUT_CODE});
    end
  end
  // Sends one record back to back; the idle data line shows the inverse so a stale byte never helps.
  task automatic send(input logic [7:0] rec[]);
    got.delete();
    foreach (rec[i]) begin
      @(negedge CLOCK);
      IN_VALID = 1'b1;
      IN_BYTE = rec[i];
      IN_LAST = (i == rec.size() - 1);
    end
    @(negedge CLOCK);
    IN_VALID = 1'b0;
    IN_LAST = 1'b0;
    IN_BYTE = ~IN_BYTE;
  endtask
endmodule // ucsaf_far

// ### testbench/tb_ucsaf_codec.sv
// Self-checking bench for the alpha-field record codec.
// Assumes ucsaf_far feeds record bytes and collects characters.
`timescale 1ns/1ps
module tb_ucsaf_codec;
  logic CLOCK, RESET_N, IN_VALID, IN_LAST, OUT_VALID, OUT_WIDE, OUT_DONE;
  logic [7:0] IN_BYTE, ENC_LEN, ENC_BYTE;
  logic [15:0] OUT_CODE, ENC_CODE;
  logic ENC_START, ENC_ALL_DEFAULT, ENC_VALID, ENC_READY, ENC_LAST, ENC_BYTE_VALID, ENC_BYTE_LAST;
  int bad_count = 0;
  int compares = 0;
  // Record end pulses seen from the decoder.
  int done_seen = 0;
  // Encoder bytes seen, record end flag above the byte.
  logic [16:0] ebytes[$];
  ucsaf_codec DUT (.CLOCK, .RESET_N, .IN_VALID, .IN_BYTE, .IN_LAST, .OUT_VALID, .OUT_CODE, .OUT_WIDE,
    .OUT_DONE, .ENC_START, .ENC_LEN, .ENC_ALL_DEFAULT, .ENC_VALID, .ENC_READY, .ENC_CODE, .ENC_LAST,
    .ENC_BYTE_VALID, .ENC_BYTE, .ENC_BYTE_LAST);
  ucsaf_far far (.CLOCK, .IN_VALID, .IN_BYTE, .IN_LAST, .OUT_VALID, .OUT_CODE, .OUT_WIDE);
  // A 125 MHz clock.
  initial begin
    CLOCK = 1'b0;
    forever #4 CLOCK = ~CLOCK;
  end
  // Registered outputs are read at the edge, before this edge's updates land.
  always @(posedge CLOCK) begin
    if (ENC_BYTE_VALID === 1'b1) begin
      ebytes.push_back({8'h00, ENC_BYTE_LAST, ENC_BYTE});
    end
  end
  // Each record end pulse stands one cycle and is counted at the following edge.
  always @(posedge CLOCK) begin
    if (OUT_DONE === 1'b1) begin
      done_seen++;
    end
  end
  task automatic end_sim;
    if (bad_count == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic cmp(input string what, input logic [16:0] exp, input logic [16:0] seen);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Compares a whole list, its length first, so a missing or extra item shows.
  task automatic check_list(input string what, input logic [16:0] exp[], input logic [16:0] seen[$]);
    cmp({what, " count"}, 17'(exp.size()), 17'(seen.size()));
    foreach (exp[i]) begin
      if (i < seen.size()) begin
        cmp(what, exp[i], seen[i]);
      end
    end
  endtask
  // A wait that hits its bound ends the run as a failure.
  task automatic guard(input int n);
    if (n >= 64) begin
      cmp("wait limit", 17'h0_0000, 17'h0_0001);
      end_sim();
    end
  endtask
  // Encodes one record; the request holds until the edge that sees ready high.
  task automatic enc_rec(input logic [7:0] len, input logic dflt, input logic [15:0] codes[]);
    int n;
    ebytes.delete();
    @(negedge CLOCK);
    ENC_LEN = len;
    ENC_ALL_DEFAULT = dflt;
    ENC_START = 1'b1;
    @(negedge CLOCK);
    ENC_START = 1'b0;
    foreach (codes[i]) begin
      ENC_VALID = 1'b1;
      ENC_CODE = codes[i];
      ENC_LAST = (i == codes.size() - 1);
      n = 0;
      #1;
      while (ENC_READY !== 1'b1 && n < 64) begin
        @(negedge CLOCK);
        #1;
        n++;
      end
      guard(n);
      @(negedge CLOCK);
    end
    ENC_VALID = 1'b0;
    ENC_LAST = 1'b0;
    n = 0;
    while (!(ebytes.size() > 0 && ebytes[ebytes.size() - 1][8]) && n < 64) begin
      @(negedge CLOCK);
      n++;
    end
    guard(n);
  endtask
  task automatic t_half_page;
    done_seen = 0;
    far.send('{8'h81, 8'h05, 8'h13, 8'h53, 8'h95, 8'hA6, 8'h41, 8'hFF, 8'hFF});
    repeat (2) @(negedge CLOCK);
    check_list("half page", '{17'h0_0053, 17'h1_0995, 17'h1_09A6, 17'h0_0041, 17'h1_09FF}, far.got);
    cmp("half page ends", 17'h0_0001, 17'(done_seen));
  endtask
  task automatic t_full_base;
    done_seen = 0;
    far.send('{8'h82, 8'h05, 8'h05, 8'h30, 8'h2D, 8'h82, 8'hD3, 8'h2D, 8'h31});
    repeat (2) @(negedge CLOCK);
    check_list("full base", '{17'h0_002D, 17'h1_0532, 17'h1_0583, 17'h0_002D, 17'h0_0031}, far.got);
    cmp("full base ends", 17'h0_0001, 17'(done_seen));
  endtask
  task automatic t_pairs;
    done_seen = 0;
    far.send('{8'h80, 8'h12, 8'h34, 8'hAB, 8'hCD, 8'hFF, 8'hFF});
    repeat (2) @(negedge CLOCK);
    check_list("pairs", '{17'h1_1234, 17'h1_ABCD}, far.got);
    cmp("pairs ends", 17'h0_0001, 17'(done_seen));
  endtask
  task automatic t_plain_lead;
    done_seen = 0;
    far.send('{8'h41, 8'h42, 8'hFF, 8'h43});
    repeat (2) @(negedge CLOCK);
    check_list("plain", '{17'h0_0041, 17'h0_0042}, far.got);
    cmp("plain ends", 17'h0_0001, 17'(done_seen));
  endtask
  task automatic t_enc_plain;
    enc_rec(8'h04, 1'b1, '{16'h0041, 16'h0042});
    check_list("plain bytes", '{17'h0_0041, 17'h0_0042, 17'h0_00FF, 17'h0_01FF}, ebytes);
  endtask
  task automatic t_enc_pair;
    enc_rec(8'h06, 1'b0, '{16'h1234, 16'h0995});
    check_list("pair bytes", '{17'h0_0080, 17'h0_0012, 17'h0_0034, 17'h0_0009, 17'h0_0095, 17'h0_01FF}, ebytes);
  endtask
  // Reset for eight cycles, then every scenario in turn.
  initial begin
    RESET_N = 1'b0;
    ENC_START = 1'b0;
    ENC_LEN = 8'h00;
    ENC_ALL_DEFAULT = 1'b0;
    ENC_VALID = 1'b0;
    ENC_CODE = 16'h0000;
    ENC_LAST = 1'b0;
    repeat (8) @(negedge CLOCK);
    RESET_N = 1'b1;
    t_half_page();
    t_full_base();
    t_pairs();
    t_plain_lead();
    t_enc_plain();
    t_enc_pair();
    end_sim();
  end
endmodule // tb_ucsaf_codec
